// File: src/pss_pkg.sv
package pss_pkg;

	// Core clock rate
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned CLK_PER_US   = CLK_HZ / 1_000_000;

	// Protection and role swap times in their own units
	localparam int unsigned OC_MIN_NS    = 2000;
	localparam int unsigned DEGLITCH_US  = 7000;
	localparam int unsigned RETRY_MS     = 128;
	localparam int unsigned SWAP_MIN_US  = 600;

	// Cycle counts derived from the times, least times rounded up
	localparam int unsigned OC_CYC       =
		(OC_MIN_NS * CLK_PER_US + 999) / 1000;
	localparam int unsigned DEGLITCH_CYC = DEGLITCH_US * CLK_PER_US;
	localparam int unsigned RETRY_CYC    = RETRY_MS * (CLK_HZ / 1000);
	localparam int unsigned SWAP_MIN_CYC = SWAP_MIN_US * CLK_PER_US;

	// Counter width for every interval timer
	localparam int unsigned CNT_W        = 23;

	// Register offsets and layout
	localparam logic [7:0]  REG_CTRL_OFS   = 8'h00;
	localparam logic [7:0]  REG_STATUS_OFS = 8'h04;
	localparam int unsigned CTRL_OFF_BIT   = 0;
	localparam logic        CTRL_OFF_RST   = 1'h0;

	// Role swap mode machine
	typedef enum logic [3:0] {
		ST_NORMAL = 4'h1,
		ST_ARMED  = 4'h2,
		ST_SWAP   = 4'h4,
		ST_LOCK   = 4'h8
	} pss_mode_t;

	// Control pins and comparator inputs
	typedef struct packed {
		logic enable;
		logic role_swap_trigger;
		logic in_discharge_ctl;
		logic out_discharge_ctl;
		logic overcurrent_guard;
		logic fast_trip_threshold;
		logic short_circuit_guard;
		logic over_voltage_guard;
		logic reverse_voltage_guard;
		logic over_temp_guard;
		logic current_limit_setting;
	} pss_pins_t;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} pss_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pss_apb_rsp_t;

	// Whole state of the sequencer
	typedef struct packed {
		pss_pins_t        s1;
		pss_pins_t        s2;
		pss_pins_t        s3;
		pss_pins_t        pins;
		pss_pins_t        prev;
		pss_mode_t        mode;
		logic [CNT_W-1:0] oc_cnt;
		logic [CNT_W-1:0] deg_cnt;
		logic [CNT_W-1:0] retry_cnt;
		logic [CNT_W-1:0] swap_cnt;
		logic             warn;
		logic             retry;
		logic             fault;
		logic             pass;
		logic             force_off;
		logic             in_dis;
		logic             out_dis;
		pss_apb_rsp_t     rsp;
	} pss_state_t;

	localparam pss_state_t ST_RESET = '{
		mode      : ST_NORMAL,
		force_off : CTRL_OFF_RST,
		default   : '0
	};

endpackage : pss_pkg

// File: src/pss_seq.sv
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
// Summary of operation
// - Overcurrent counts only after staying above limit longer than 2us.
// - Fast-trip comparator turns the pass switch off with no deglitch.
// - Low output voltage shuts off and retries every 128 ms.
// - Any protection condition raises the internal warning.
// - Fault flag goes low only after 7 ms of continuous warning.
// - Fault flag stays low, switch off, until all conditions clear.
// - Role-swap rising edge arms swap control regardless of enable.
// - Pulse wider than 600us turns switch on after its fall, absent reverse.
// - After swap turn-on, enable rising edges are ignored.
// - After swap turn-on, enable falling edge shuts the switch off.
// - After that shutdown, stay off until enable or swap rising edge.
// - Input discharge follows its control pin, independent of output.
// - Output discharge follows its pin; both may discharge together.
// - Undriven discharge pins read zero, so discharge is off by default.
// - Reverse voltage turns switch off; it returns once reverse clears.
// - Over-temperature turns switch off until the hysteretic level clears.
module pss_seq #(
	parameter int unsigned DEGLITCH_CYC_P = pss_pkg::DEGLITCH_CYC,
	parameter int unsigned RETRY_CYC_P    = pss_pkg::RETRY_CYC,
	parameter int unsigned SWAP_MIN_CYC_P = pss_pkg::SWAP_MIN_CYC
) (
	input  wire logic                 core_clk_i,
	input  wire logic                 reset_n_i,
	input  wire pss_pkg::pss_pins_t   pins_i,
	input  wire pss_pkg::pss_apb_req_t apb_i,
	output logic                      pass_on_o,
	output logic                      fault_flag_n_o,
	output logic                      in_discharge_o,
	output logic                      out_discharge_o,
	output pss_pkg::pss_apb_rsp_t     apb_o
);
	import pss_pkg::*;

	// Refuse timer settings the counters cannot hold
	if (DEGLITCH_CYC_P < 2 || DEGLITCH_CYC_P >= (1 << CNT_W) ||
	    RETRY_CYC_P < 8 || RETRY_CYC_P >= (1 << CNT_W) ||
	    SWAP_MIN_CYC_P < 1 || SWAP_MIN_CYC_P >= (1 << CNT_W))
	begin : g_bad_param
		$error("pss_seq: timer parameter out of range");
	end

	localparam logic [CNT_W-1:0] OC_LIM  = CNT_W'(OC_CYC);
	localparam logic [CNT_W-1:0] DEG_END = CNT_W'(DEGLITCH_CYC_P - 1);
	localparam logic [CNT_W-1:0] RET_END = CNT_W'(RETRY_CYC_P - 1);
	localparam logic [CNT_W-1:0] SWP_LIM = CNT_W'(SWAP_MIN_CYC_P);

	pss_state_t s_r;
	pss_state_t s_nxt;

	// Saturating increment shared by the overcurrent, deglitch and swap timers
	function automatic logic [CNT_W-1:0] sat_inc(
		input logic [CNT_W-1:0] cnt,
		input logic [CNT_W-1:0] lim
	);
		sat_inc = (cnt >= lim) ? lim : cnt + CNT_W'(1);
	endfunction : sat_inc

	// Rising edge of a filtered pin
	function automatic logic rose(input logic now, input logic was);
		rose = now & ~was;
	endfunction : rose

	logic en_rise;
	logic en_fall;
	logic swap_rise;
	logic oc_trip;
	logic block_on;
	logic want_on;
	logic apb_setup;
	logic apb_done;
	pss_pins_t agree;

	// Edges and protection summary taken from the filtered pins
	always_comb
	begin
		agree     = ~(s_r.s2 ^ s_r.s3);
		en_rise   = rose(s_r.pins.enable, s_r.prev.enable);
		en_fall   = rose(s_r.prev.enable, s_r.pins.enable);
		swap_rise = rose(s_r.pins.role_swap_trigger,
		                 s_r.prev.role_swap_trigger);
		oc_trip   = s_r.pins.overcurrent_guard &
		            (s_r.oc_cnt == OC_LIM);
		block_on  = s_r.pins.fast_trip_threshold |
		            s_r.retry |
		            (s_r.pins.short_circuit_guard & s_r.pass) |
		            s_r.fault |
		            s_r.pins.reverse_voltage_guard |
		            s_r.pins.over_temp_guard |
		            s_r.pins.over_voltage_guard |
		            s_r.pins.current_limit_setting |
		            s_r.force_off;
		apb_setup = apb_i.psel & apb_i.penable & ~s_r.rsp.pready;
		apb_done  = apb_i.psel & apb_i.penable & s_r.rsp.pready;
	end

	// Next state of the whole sequencer
	always_comb
	begin
		s_nxt = s_r;

		// Three-stage pin capture; a change counts once stages agree
		s_nxt.s1   = pins_i;
		s_nxt.s2   = s_r.s1;
		s_nxt.s3   = s_r.s2;
		s_nxt.pins = (agree & s_r.s2) | (~agree & s_r.pins);
		s_nxt.prev = s_r.pins;

		// Overcurrent must persist past the filter before it counts
		s_nxt.oc_cnt = s_r.pins.overcurrent_guard ?
		               sat_inc(s_r.oc_cnt, OC_LIM) : '0;

		// Short-circuit retry window; sensed only while switch is on
		if (s_r.retry)
		begin
			if (s_r.retry_cnt == RET_END)
			begin
				s_nxt.retry     = 1'b0;
				s_nxt.retry_cnt = '0;
			end
			else
			begin
				s_nxt.retry_cnt = s_r.retry_cnt + CNT_W'(1);
			end
		end
		else if (s_r.pins.short_circuit_guard && s_r.pass)
		begin
			s_nxt.retry     = 1'b1;
			s_nxt.retry_cnt = '0;
		end

		// Warning is any live exception, registered for a clean status
		s_nxt.warn = s_r.pins.over_voltage_guard |
		             s_r.pins.reverse_voltage_guard |
		             s_r.pins.over_temp_guard |
		             s_r.pins.fast_trip_threshold |
		             s_r.retry | oc_trip |
		             s_r.pins.current_limit_setting;

		// Deglitch: a dropout restarts the count and releases the flag
		if (!s_r.warn)
		begin
			s_nxt.deg_cnt = '0;
			s_nxt.fault   = 1'b0;
		end
		else if (!s_r.fault)
		begin
			s_nxt.deg_cnt = sat_inc(s_r.deg_cnt, DEG_END);
			s_nxt.fault   = (s_r.deg_cnt == DEG_END);
		end

		// Role swap machine; a swap edge wins from any mode
		if (swap_rise)
		begin
			s_nxt.mode     = ST_ARMED;
			s_nxt.swap_cnt = '0;
		end
		else
		begin
			case (s_r.mode)
				ST_ARMED:
				begin
					if (s_r.pins.role_swap_trigger)
					begin
						s_nxt.swap_cnt = sat_inc(s_r.swap_cnt,
						                         SWP_LIM);
					end
					else
					begin
						s_nxt.mode = (s_r.swap_cnt >= SWP_LIM) ?
						             ST_SWAP : ST_NORMAL;
					end
				end
				ST_SWAP:
				begin
					// Enable rising edges fall through untouched
					if (en_fall)
					begin
						s_nxt.mode = ST_LOCK;
					end
				end
				ST_LOCK:
				begin
					if (en_rise)
					begin
						s_nxt.mode = ST_NORMAL;
					end
				end
				default:
				begin
					s_nxt.mode = ST_NORMAL;
				end
			endcase
		end

		// Swap mode holds the switch on; a pending reverse delays it
		case (s_r.mode)
			ST_SWAP:  want_on = 1'b1;
			ST_LOCK:  want_on = 1'b0;
			default:  want_on = s_r.pins.enable;
		endcase
		s_nxt.pass = want_on & ~block_on;

		// Discharge paths follow their own pins independently
		s_nxt.in_dis  = s_r.pins.in_discharge_ctl;
		s_nxt.out_dis = s_r.pins.out_discharge_ctl;

		// APB slave: one wait state, answer registered
		s_nxt.rsp.pready  = apb_setup;
		s_nxt.rsp.pslverr = 1'b0;
		if (apb_setup)
		begin
			if (apb_i.paddr == REG_CTRL_OFS)
			begin
				s_nxt.rsp.prdata = {31'h0, s_r.force_off};
			end
			else if (apb_i.paddr == REG_STATUS_OFS)
			begin
				s_nxt.rsp.prdata = {13'h0, s_r.pins, s_r.mode,
				                    s_r.retry, s_r.warn,
				                    s_r.fault, s_r.pass};
			end
			else
			begin
				s_nxt.rsp.prdata  = 32'h0;
				s_nxt.rsp.pslverr = 1'b1;
			end
		end
		if (apb_done && apb_i.pwrite && apb_i.paddr == REG_CTRL_OFS)
		begin
			s_nxt.force_off = apb_i.pwdata[CTRL_OFF_BIT];
		end
	end

	// Single state register; reset leaves the switch off
	always_ff @(posedge core_clk_i)
	begin
		if (!reset_n_i)
		begin
			s_r <= ST_RESET;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign pass_on_o       = s_r.pass;
	assign fault_flag_n_o  = ~s_r.fault;
	assign in_discharge_o  = s_r.in_dis;
	assign out_discharge_o = s_r.out_dis;
	assign apb_o           = s_r.rsp;

	property p_oc_filter;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		oc_trip |-> $past(s_r.pins.overcurrent_guard, OC_CYC);
	endproperty
	a_oc_filter: assert property (p_oc_filter)
		else $error("overcurrent counted before filter");

	property p_fast_off;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		s_r.pins.fast_trip_threshold |=> !s_r.pass;
	endproperty
	a_fast_off: assert property (p_fast_off)
		else $error("switch on after fast trip");

	property p_retry_len;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$rose(s_r.retry) |-> !s_r.pass [*8];
	endproperty
	a_retry_len: assert property (p_retry_len)
		else $error("switch on inside retry window");

	property p_warn;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		s_r.pins.reverse_voltage_guard || s_r.pins.over_temp_guard
		|=> s_r.warn;
	endproperty
	a_warn: assert property (p_warn)
		else $error("warning missing for live condition");

	property p_deglitch;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		$fell(fault_flag_n_o) |->
			$past(s_r.deg_cnt) == DEG_END && $past(s_r.warn);
	endproperty
	a_deglitch: assert property (p_deglitch)
		else $error("fault flag before deglitch end");

	property p_fault_hold;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		s_r.fault |=> !s_r.pass;
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("switch on while fault flagged");

	property p_arm;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		swap_rise |=> s_r.mode == ST_ARMED && s_r.swap_cnt == '0;
	endproperty
	a_arm: assert property (p_arm)
		else $error("swap edge did not arm");

	property p_swap_on;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		s_r.mode == ST_SWAP && !block_on && !swap_rise
		|=> s_r.pass;
	endproperty
	a_swap_on: assert property (p_swap_on)
		else $error("swap mode did not turn switch on");

	property p_lock;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		s_r.mode == ST_SWAP && en_fall && !swap_rise
		|=> s_r.mode == ST_LOCK ##1 !s_r.pass;
	endproperty
	a_lock: assert property (p_lock)
		else $error("enable fall did not shut swap mode");

	property p_restart;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		!s_r.warn |=> s_r.deg_cnt == '0 && fault_flag_n_o;
	endproperty
	a_restart: assert property (p_restart)
		else $error("deglitch not restarted");

	property p_disc;
		@(posedge core_clk_i) disable iff (!reset_n_i)
		##1 in_discharge_o == $past(s_r.pins.in_discharge_ctl) &&
		out_discharge_o == $past(s_r.pins.out_discharge_ctl);
	endproperty
	a_disc: assert property (p_disc)
		else $error("discharge does not follow pins");

endmodule : pss_seq

// File: tb/pss_ctl_model.sv
`timescale 1ns/10ps
// Controller at the far side: drives enable, swap, discharge and sense pins
module pss_ctl_model
	import pss_pkg::*;
#(
	parameter int unsigned SWAP_MIN_CYC_P = 10
) (
	input  wire logic          core_clk_i,
	output pss_pkg::pss_pins_t pins_o
);
	// Undriven pins sit low, as the pull-downs would hold them
	initial pins_o = '0;

	// Change one pin just after a rising edge
	task automatic set_pin(input int idx, input logic val);
		@(posedge core_clk_i);
		pins_o[idx] <= val;
	endtask : set_pin

	// Swap pulse of minimum width plus extra cycles, then back low
	task automatic swap_pulse(input int extra);
		set_pin(9, 1'b1);
		repeat (int'(SWAP_MIN_CYC_P) + extra) @(posedge core_clk_i);
		pins_o[9] <= 1'b0;
	endtask : swap_pulse
endmodule : pss_ctl_model

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
	import pss_pkg::*;
	// Pin positions inside the packed pin struct
	localparam int P_EN = 10, P_DI = 8, P_DO = 7, P_OC = 6, P_FT = 5;
	localparam int P_SC = 4, P_OV = 3, P_RV = 2, P_OT = 1, P_LIM = 0;
	logic         clk;
	logic         reset_n;
	pss_pins_t    pins;
	pss_apb_req_t req;
	pss_apb_rsp_t rsp;
	logic         pass_on;
	logic         fault_n;
	logic         in_dis;
	logic         out_dis;
	logic [31:0]  rdat;
	logic         rerr;
	int           n_fail;
	int           n_tests;

	// Short counts keep the run brief
	pss_seq #(
		.DEGLITCH_CYC_P(20),
		.RETRY_CYC_P   (30),
		.SWAP_MIN_CYC_P(10)
	) pss_seq_i (
		.core_clk_i     (clk),
		.reset_n_i      (reset_n),
		.pins_i         (pins),
		.apb_i          (req),
		.pass_on_o      (pass_on),
		.fault_flag_n_o (fault_n),
		.in_discharge_o (in_dis),
		.out_discharge_o(out_dis),
		.apb_o          (rsp)
	);

	pss_ctl_model #(
		.SWAP_MIN_CYC_P(10)
	) pss_ctl_model_i (
		.core_clk_i(clk),
		.pins_o    (pins)
	);

	// 50 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic complete_run();
		$display("Tests %0d, failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic pin(input int i, input logic v);
		pss_ctl_model_i.set_pin(i, v);
	endtask : pin

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0,
			pwrite: wr, pwdata: wd};
		@(posedge clk);
		req.penable <= 1'b1;
		@(posedge clk);
		// Wait for the answer; only the watchdog ends a hung transfer
		while (rsp.pready !== 1'b1)
			@(posedge clk);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic t_reset();
		chk(pass_on, 1'b0);
		chk(fault_n, 1'b1);
		chk({in_dis, out_dis}, 2'h0);
		apb(1'b0, REG_CTRL_OFS, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rerr, 1'b1);
	endtask : t_reset

	// All four discharge pin settings
	task automatic t_disc();
		for (int k = 0; k < 4; k++)
		begin
			pin(P_DI, k[1]);
			pin(P_DO, k[0]);
			cyc(8);
			chk(in_dis, k[1]);
			chk(out_dis, k[0]);
		end
		pin(P_DI, 1'b0);
		pin(P_DO, 1'b0);
	endtask : t_disc

	// Fast-trip, reverse, over-temperature, over-voltage and the off bit each drop the switch, which returns once clear
	task automatic t_block();
		int b[4] = '{P_FT, P_RV, P_OT, P_OV};
		pin(P_EN, 1'b1);
		cyc(8);
		chk(pass_on, 1'b1);
		foreach (b[i])
		begin
			pin(b[i], 1'b1);
			cyc(6);
			chk(pass_on, 1'b0);
			pin(b[i], 1'b0);
			cyc(8);
			chk(pass_on, 1'b1);
		end
		apb(1'b1, REG_CTRL_OFS, 32'h1);
		cyc(6);
		chk(pass_on, 1'b0);
		apb(1'b1, REG_CTRL_OFS, 32'h0);
		cyc(6);
		chk(pass_on, 1'b1);
	endtask : t_block

	// Overcurrent filter, warning, deglitch and release
	task automatic t_oc();
		pin(P_OC, 1'b1);
		cyc(60);
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		chk(rdat[2], 1'b0);
		pin(P_OC, 1'b0);
		cyc(10);
		pin(P_OC, 1'b1);
		cyc(112);
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		chk(rdat[2], 1'b1);
		chk(fault_n, 1'b1);
		cyc(25);
		chk({fault_n, pass_on}, 2'h0);
		pin(P_OC, 1'b0);
		cyc(2);
		chk(fault_n, 1'b0);
		cyc(10);
		chk({fault_n, pass_on}, 2'h3);
		pin(P_LIM, 1'b1);
		cyc(15);
		pin(P_LIM, 1'b0);
		cyc(3);
		pin(P_LIM, 1'b1);
		cyc(15);
		chk(fault_n, 1'b1);
		pin(P_LIM, 1'b0);
		cyc(8);
	endtask : t_oc

	// Low output voltage shuts off for one retry period
	task automatic t_retry();
		pin(P_SC, 1'b1);
		cyc(5);
		pin(P_SC, 1'b0);
		cyc(20);
		chk(pass_on, 1'b0);
		cyc(20);
		chk(pass_on, 1'b1);
	endtask : t_retry

	// Role swap: narrow pulse refused, wide pulse turns on, enable edges
	task automatic t_swap();
		pin(P_EN, 1'b0);
		cyc(8);
		pss_ctl_model_i.swap_pulse(-5);
		cyc(10);
		chk(pass_on, 1'b0);
		pss_ctl_model_i.swap_pulse(2);
		cyc(10);
		chk(pass_on, 1'b1);
		pin(P_EN, 1'b1);
		cyc(8);
		chk(pass_on, 1'b1);
		pin(P_EN, 1'b0);
		cyc(8);
		chk(pass_on, 1'b0);
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		chk(rdat[7:4], 4'h8);
		cyc(30);
		chk(pass_on, 1'b0);
		pin(P_EN, 1'b1);
		cyc(8);
		chk(pass_on, 1'b1);
	endtask : t_swap

	// Reset in mid-run drops the switch; the enable level brings it back
	task automatic t_rerun();
		@(posedge clk);
		reset_n <= 1'b0;
		cyc(2);
		chk(pass_on, 1'b0);
		reset_n <= 1'b1;
		cyc(2);
		chk({fault_n, pass_on}, 2'h2);
		cyc(8);
		chk(pass_on, 1'b1);
	endtask : t_rerun

	// Watchdog well beyond the expected run of about 600 cycles
	initial
	begin
		cyc(6000);
		n_fail++;
		complete_run();
	end

	// Reset for 20 cycles, then every scenario in turn
	initial
	begin
		n_fail  = 0;
		n_tests = 0;
		reset_n = 1'b0;
		req     = '0;
		cyc(20);
		reset_n <= 1'b1;
		cyc(6);
		t_reset();
		t_disc();
		t_block();
		t_oc();
		t_retry();
		t_swap();
		t_rerun();
		complete_run();
	end
endmodule : tb
